// ==== bench/sacc_ctrl_bench.sv ====
/*
 * Self-checking bench for the converter control block: routing, reference,
 * start sequence, timing, result format, interrupt flag and power gating.
 * Assumes sacc_pkg is compiled first and that sacc_ctrl checks itself inline.
 */
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl_bench;
    import sacc_pkg::*;
    logic mclk, rst_n, start_bit, pwr, fmt, gie, cie, irq_clear;
    logic [3:0] chan, src;
    logic [2:0] div;
    logic [1:0] refsel;
    logic [11:0] core_code;
    logic busy, irq_flag, irq_out, core_power, core_clk_en, core_sample;
    logic [7:0] hi, lo, conn;
    logic [2:0] isrc;
    logic [1:0] rroute;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 60;

    sacc_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .start_bit(start_bit),
        .converter_power_enable(pwr), .result_format_select(fmt),
        .external_channel_select(chan), .input_source_select(src),
        .converter_clock_divider_select(div),
        .reference_source_select(refsel),
        .global_interrupt_enable(gie), .converter_interrupt_enable(cie),
        .irq_clear(irq_clear), .core_code(core_code),
        .conversion_busy_flag(busy), .result_high_byte(hi),
        .result_low_byte(lo), .irq_flag(irq_flag), .irq_out(irq_out),
        .core_power(core_power), .core_clk_en(core_clk_en),
        .core_sample(core_sample), .channel_connect(conn),
        .internal_source(isrc), .reference_route(rroute));

    // 50 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ****************************************************************
    // comparison, model and closing
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // routing model: {internal source, pin switches}, all off when unpowered
    function automatic logic [10:0] route_exp(input logic [3:0] s,
        input logic [3:0] c, input logic en);
        logic [7:0] p;
        logic [2:0] i;
        p = 8'h00;
        i = 3'h0;
        if (s == 4'h0 || s == 4'h4 || s[3:2] == 2'b11) begin
            if (!c[3]) p = 8'h01 << c[2:0];
        end else if (s[3]) i = 3'h7;
        else i = s[2] ? 3'(s[1:0]) + 3'h3 : {1'b0, s[1:0]};
        return en ? {i, p} : 11'h000;
    endfunction

    task automatic end_of_test;
        $display("tests run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // watchdog: the whole run needs well under 40000 cycles
    initial begin
        #(20 * 40000);
        fail_count++;
        end_of_test();
    end

    // ****************************************************************
    // one conversion: start held for hold + 1 cycles, optional restart
    // ****************************************************************
    task automatic conv(input int s, input logic f, input int hold,
        input bit rs);
        int n;
        int per;
        int t;
        logic [11:0] code;
        logic g, e;
        code = 12'($random(seed));
        g = 1'($random(seed));
        e = 1'($random(seed));
        per = 1 << s;
        @(posedge mclk);
        irq_clear <= 1'b1;
        div <= 3'(s);
        fmt <= f;
        core_code <= code;
        gie <= g;
        cie <= e;
        @(posedge mclk);
        irq_clear <= 1'b0;
        start_bit <= 1'b1;
        repeat (hold) @(posedge mclk);
        @(negedge mclk);
        check(16'({busy, irq_flag}), 16'h0000);
        @(posedge mclk);
        start_bit <= 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        check(16'(busy), 16'h0001);
        check(16'(core_sample), 16'h0001);
        t = int'(core_clk_en);
        if (rs) begin
            repeat (6 * per) @(negedge mclk);
            @(posedge mclk);
            start_bit <= 1'b1;
            @(posedge mclk);
            start_bit <= 1'b0;
        end
        n = 0;
        while (busy === 1'b1 && n < 4000) begin
            @(negedge mclk);
            n++;
            t += int'(core_clk_en);
        end
        if (!rs) check(16'(t), 16'h0010);
        check(16'(n >= 16 * per - per && n <= 16 * per + per + 3), 16'h1);
        check(16'(busy), 16'h0000);
        if (f) check({hi, lo}, {4'h0, code});
        else check({hi, lo}, {code, 4'h0});
        check(16'({irq_flag, irq_out}), 16'({1'b1, g & e}));
        $display("conversion div %0d fmt %0d done", s, f);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        {start_bit, pwr, fmt, gie, cie, irq_clear} = 6'h00;
        {chan, src, div, refsel} = 13'h0000;
        core_code = 12'h000;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        check(16'({busy, irq_flag}), 16'h0000);
        check({hi, lo}, 16'h0000);
        // every source and channel code, powered and unpowered
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 256; k++) begin
                @(posedge mclk);
                pwr <= 1'(p);
                src <= 4'(k >> 4);
                chan <= 4'(k);
                refsel <= 2'(k);
                @(negedge mclk);
                check(16'({isrc, conn}), 16'(route_exp(src, chan, pwr)));
                check(16'(rroute), 16'(refsel[1] ? 2'h2 : refsel));
                check(16'(core_power), 16'(pwr));
            end
        end
        $display("routing test done");
        // conversions across dividers and both formats
        // codes 5 to 7 give 0.64 to 2.56 us at 50 MHz, inside the advised
        // window; the faster codes only exercise the divider
        repeat (50) @(posedge mclk); // settling delay after power-up
        for (int s = 0; s < 8; s++) conv(s, 1'(s), 1, 0);
        conv(7, 1'b0, 1, 0);
        conv(0, 1'b1, 20, 0);
        conv(1, 1'b0, 1, 1);
        // irq flag clears and busy stays low with no start
        @(posedge mclk);
        irq_clear <= 1'b1;
        @(posedge mclk);
        irq_clear <= 1'b0;
        @(negedge mclk);
        check(16'({irq_flag, irq_out, busy}), 16'h0000);
        // power drop mid-conversion aborts and keeps the result
        @(posedge mclk);
        div <= 3'h1;
        core_code <= ~core_code;
        start_bit <= 1'b1;
        @(posedge mclk);
        start_bit <= 1'b0;
        repeat (10) @(posedge mclk);
        pwr <= 1'b0;
        repeat (2) @(negedge mclk);
        check(16'(busy), 16'h0000);
        repeat (40) @(negedge mclk);
        check(16'(irq_flag), 16'h0000);
        check({hi, lo}, {~core_code, 4'h0});
        // start while unpowered is ignored
        @(posedge mclk);
        start_bit <= 1'b1;
        @(posedge mclk);
        start_bit <= 1'b0;
        repeat (6) @(negedge mclk);
        check(16'(busy), 16'h0000);
        $display("power test done");
        end_of_test();
    end
endmodule // sacc_ctrl_bench
`default_nettype wire

// ==== hdl/sacc_ctrl.sv ====
/*
 * Control logic around one 12-bit successive-approximation converter:
 * input routing, clock divider, start/busy sequencer, result formatting
 * and interrupt request.
 * Assumes the control bits come from flip-flops on mclk, the analog core
 * delivers its 12-bit code on core_code, and the interrupt flag is
 * cleared by the interrupt controller through irq_clear.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Source codes 0000, 0100, 11xx route the selected external channel.
// - Other source codes pick supply, fractions, reference fractions or ground.
// - Any internal source disconnects all external channels.
// - Channel codes 0-7 connect a pin; 8-15 leave the input floating.
// - Start is a high-then-low write sequence on the start bit.
// - Busy rises on a started conversion and holds through it.
// - Busy falls when the conversion completes.
// - Completion sets the interrupt request flag regardless of enables.
// - Interrupt reaches the processor only with both enables high.
// - Converter clock is system clock divided by 2 to the select value.
// - Conversions run only while the power enable is high.
// - Four sampling periods then twelve conversion periods, sixteen total.
// - Once started the conversion runs on in hardware.
// - After busy falls the result stays in the high and low bytes.
// - Clearing power enable powers the core down.
// - Result is a 12-bit unsigned code, step equals reference over 4096.
// - Format bit selects 8/4 or 4/8 split of the result bytes.
// - Reference select: 00 supply, 01 pin, 1x internal amplified output.
// - Busy is read-only; writes cannot change it.
// - While disabled the result bytes keep their contents.
module sacc_ctrl
    import sacc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start_bit,
    input wire logic converter_power_enable,
    input wire logic result_format_select,
    input wire logic [3:0] external_channel_select,
    input wire logic [3:0] input_source_select,
    input wire logic [2:0] converter_clock_divider_select,
    input wire logic [1:0] reference_source_select,
    input wire logic global_interrupt_enable,
    input wire logic converter_interrupt_enable,
    input wire logic irq_clear,
    input wire logic [11:0] core_code,
    output logic conversion_busy_flag,
    output logic [7:0] result_high_byte,
    output logic [7:0] result_low_byte,
    output logic irq_flag,
    output logic irq_out,
    output logic core_power,
    output logic core_clk_en,
    output logic core_sample,
    output logic [7:0] channel_connect,
    output logic [2:0] internal_source,
    output logic [1:0] reference_route
);

    // ************************************************************
    // input routing
    // ************************************************************
    logic src_external;
    logic chan_valid;
    logic [7:0] chan_onehot;
    logic [2:0] int_sel;

    // external when 0000, 0100 or 11xx; everything else is internal
    assign src_external = (input_source_select == SRC_EXT_A) ||
        (input_source_select == SRC_EXT_B) ||
        (input_source_select[SRC_GND_BIT] &&
         input_source_select[SRC_EXT_HI_BIT]);
    assign chan_valid = !external_channel_select[CHAN_FLOAT_BIT];
    assign chan_onehot = 8'h01 << external_channel_select[2:0];

    // internal path selected only when the external one is not
    always_comb begin
        int_sel = INT_NONE;
        if (!src_external) begin
            if (input_source_select[SRC_GND_BIT]) begin
                int_sel = INT_GND;
            end else begin
                unique case (input_source_select)
                    SRC_VDD: int_sel = INT_VDD;
                    SRC_VDD_HALF: int_sel = INT_VDD_HALF;
                    SRC_VDD_QUARTER: int_sel = INT_VDD_QUARTER;
                    SRC_VREF: int_sel = INT_VREF;
                    SRC_VREF_HALF: int_sel = INT_VREF_HALF;
                    SRC_VREF_QUARTER: int_sel = INT_VREF_QUARTER;
                    default: int_sel = INT_NONE;
                endcase
            end
        end
    end

    // a switched-off core gets no channel or internal source input; the reference route stays set
    assign channel_connect = (src_external && chan_valid &&
        converter_power_enable) ? chan_onehot : 8'h00;
    assign internal_source = converter_power_enable ? int_sel : INT_NONE;
    assign reference_route = reference_source_select[REF_INT_BIT] ?
        2'h2 : reference_source_select;
    assign core_power = converter_power_enable;

    // ************************************************************
    // converter clock divider
    // ************************************************************
    logic [DIV_BITS-1:0] div_q;
    logic [DIV_BITS-1:0] div_d;
    logic [DIV_BITS-1:0] div_mask;
    logic tick;

    // divisor 2^sel: tick when the low sel bits of the counter are all ones
    assign div_mask = 7'(8'h01 << converter_clock_divider_select) - 7'h01;
    assign tick = ((div_q & div_mask) == div_mask);
    assign div_d = converter_power_enable ? div_q + 7'h01 : 7'h00;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_d;
        end
    end

    // ************************************************************
    // start detection
    // ************************************************************
    logic start_q;
    logic armed_q;
    logic armed_d;
    logic start_go;

    // arm on a rising start bit, fire on the following falling edge
    assign start_go = armed_q && start_q && !start_bit &&
        converter_power_enable;
    assign armed_d = (start_bit && !start_q) ? 1'b1 :
        ((!start_bit) ? 1'b0 : armed_q);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            start_q <= start_bit;
            armed_q <= armed_d;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    sacc_state_type state_q;
    sacc_state_type state_d;
    logic [4:0] per_q;
    logic [4:0] per_d;
    logic done;

    // done in the cycle the sixteenth converter period ends
    assign done = (state_q == SEQ_CONVERT) && tick &&
        converter_power_enable && // power loss never loads the bytes
        (per_q == TOTAL_PERIODS - 5'h01);

    // a fresh start always wins and restarts sampling
    always_comb begin
        state_d = state_q;
        per_d = per_q;
        if (!converter_power_enable) begin
            state_d = SEQ_IDLE;
            per_d = 5'h00;
        end else if (start_go) begin
            state_d = SEQ_SAMPLE;
            per_d = 5'h00;
        end else begin
            unique case (state_q)
                SEQ_IDLE: begin
                    per_d = 5'h00;
                end
                SEQ_SAMPLE: begin
                    if (tick) begin
                        per_d = per_q + 5'h01;
                        if (per_q == SAMPLE_PERIODS - 5'h01) begin
                            state_d = SEQ_CONVERT;
                        end
                    end
                end
                SEQ_CONVERT: begin
                    if (done) begin
                        state_d = SEQ_IDLE;
                        per_d = 5'h00;
                    end else if (tick) begin
                        per_d = per_q + 5'h01;
                    end
                end
                default: begin
                    state_d = SEQ_IDLE;
                    per_d = 5'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SEQ_IDLE;
            per_q <= 5'h00;
        end else begin
            state_q <= state_d;
            per_q <= per_d;
        end
    end

    // busy comes only from the sequencer; no input can write it
    assign conversion_busy_flag = (state_q != SEQ_IDLE);
    assign core_sample = (state_q == SEQ_SAMPLE);
    assign core_clk_en = (state_q != SEQ_IDLE) && tick;

    // ************************************************************
    // result and interrupt
    // ************************************************************
    logic [7:0] hi_d;
    logic [7:0] lo_d;
    logic irq_d;

    // format 0: 11..4 / 3..0 in top nibble; format 1: 11..8 / 7..0
    assign hi_d = result_format_select ? {4'h0, core_code[11:8]} :
        core_code[11:4];
    assign lo_d = result_format_select ? core_code[7:0] :
        {core_code[3:0], 4'h0};
    // completion sets the flag even in the clear cycle
    assign irq_d = done || (irq_flag && !irq_clear);

    // bytes load only at completion, so disable leaves them alone
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            result_high_byte <= RESULT_RESET[11:4];
            result_low_byte <= RESULT_RESET[7:0];
            irq_flag <= 1'b0;
        end else begin
            if (done) begin
                result_high_byte <= hi_d;
                result_low_byte <= lo_d;
            end
            irq_flag <= irq_d;
        end
    end

    assign irq_out = irq_flag && global_interrupt_enable &&
        converter_interrupt_enable;

    // ************************************************************
    // assertions
    // ************************************************************
    // shared sequences: the start event, the busy run after it, and one
    // cycle in which a divide-by-one conversion is left undisturbed
    sequence s_start;
        start_go;
    endsequence

    sequence s_busy_run;
        conversion_busy_flag [*2];
    endsequence

    sequence s_div1_start;
        start_go && (converter_clock_divider_select == 3'h0);
    endsequence

    sequence s_quiet;
        converter_power_enable && !start_go &&
            (converter_clock_divider_select == 3'h0);
    endsequence

    a_busy_after_start: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_start |=> s_busy_run)
        else $error("busy did not rise after start");

    a_done_clears_busy: assert property (
        @(posedge mclk) disable iff (!rst_n)
        done && !start_go |=> !conversion_busy_flag)
        else $error("busy still set after completion");

    a_irq_on_done: assert property (
        @(posedge mclk) disable iff (!rst_n)
        done |=> irq_flag)
        else $error("interrupt flag not set at completion");

    a_irq_gating: assert property (
        @(posedge mclk) disable iff (!rst_n)
        irq_out == (irq_flag && global_interrupt_enable
            && converter_interrupt_enable))
        else $error("interrupt output gating wrong");

    a_internal_isolates: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !src_external |-> channel_connect == 8'h00)
        else $error("external channel connected with internal source");

    a_float_channel: assert property (
        @(posedge mclk) disable iff (!rst_n)
        external_channel_select[CHAN_FLOAT_BIT] |-> channel_connect == 8'h00)
        else $error("channel connected for floating code");

    a_disabled_idle: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !converter_power_enable |=> !conversion_busy_flag)
        else $error("busy while converter disabled");

    a_result_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !converter_power_enable |=> $stable(result_high_byte)
            && $stable(result_low_byte))
        else $error("result changed while disabled");

    // start cycle plus sixteen quiet ones: the last of them is the done tick
    a_div1_period: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_div1_start ##1 s_quiet [*8] ##1 s_quiet [*8] |-> done)
        else $error("divide-by-one conversion not 16 periods");

    a_format_low: assert property (
        @(posedge mclk) disable iff (!rst_n)
        done && !result_format_select |=>
            result_low_byte[3:0] == 4'h0)
        else $error("low byte format wrong");

    a_format_high: assert property (
        @(posedge mclk) disable iff (!rst_n)
        done && result_format_select |=> result_high_byte[7:4] == 4'h0)
        else $error("high byte format wrong");

    a_restart_sample: assert property (
        @(posedge mclk) disable iff (!rst_n)
        start_go && conversion_busy_flag |=>
            core_sample && conversion_busy_flag)
        else $error("restart did not return to sampling");

    a_irq_clear: assert property (
        @(posedge mclk) disable iff (!rst_n)
        irq_clear && !done |=> !irq_flag)
        else $error("interrupt flag not cleared");

    a_power_off_routing: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !converter_power_enable |-> channel_connect == 8'h00 &&
            internal_source == INT_NONE && !core_power)
        else $error("routing live while converter unpowered");

endmodule : sacc_ctrl

`default_nettype wire

// ==== include/sacc_pkg.sv ====
/*
 * Constants, encodings and types for the converter control block.
 * Assumes a single system clock and an analog core driven by plain ports.
 */
package sacc_pkg;

    // ************************************************************
    // input source encodings
    // ************************************************************
    localparam logic [3:0] SRC_EXT_A = 4'h0;
    localparam logic [3:0] SRC_VDD = 4'h1;
    localparam logic [3:0] SRC_VDD_HALF = 4'h2;
    localparam logic [3:0] SRC_VDD_QUARTER = 4'h3;
    localparam logic [3:0] SRC_EXT_B = 4'h4;
    localparam logic [3:0] SRC_VREF = 4'h5;
    localparam logic [3:0] SRC_VREF_HALF = 4'h6;
    localparam logic [3:0] SRC_VREF_QUARTER = 4'h7;
    localparam int SRC_GND_BIT = 3;
    localparam int SRC_EXT_HI_BIT = 2;

    // internal source selector codes driven to the analog core
    localparam logic [2:0] INT_NONE = 3'h0;
    localparam logic [2:0] INT_VDD = 3'h1;
    localparam logic [2:0] INT_VDD_HALF = 3'h2;
    localparam logic [2:0] INT_VDD_QUARTER = 3'h3;
    localparam logic [2:0] INT_VREF = 3'h4;
    localparam logic [2:0] INT_VREF_HALF = 3'h5;
    localparam logic [2:0] INT_VREF_QUARTER = 3'h6;
    localparam logic [2:0] INT_GND = 3'h7;

    // ************************************************************
    // channel, reference and timing constants
    // ************************************************************
    localparam int NUM_CHANNELS = 8;
    localparam int CHAN_FLOAT_BIT = 3;
    localparam logic [1:0] REF_VDD = 2'h0;
    localparam logic [1:0] REF_PIN = 2'h1;
    localparam int REF_INT_BIT = 1;
    localparam int RESULT_BITS = 12;
    localparam int DIV_BITS = 7;
    localparam logic [4:0] SAMPLE_PERIODS = 5'h04;
    localparam logic [4:0] CONVERT_PERIODS = 5'h0C;
    localparam logic [4:0] TOTAL_PERIODS = 5'h10;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // sequencer states, gray coded along idle -> sample -> convert
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SAMPLE = 2'b01,
        SEQ_CONVERT = 2'b11
    } sacc_state_type;

endpackage : sacc_pkg
